// ### hdl/pecr_pkg.sv
// Purpose: Constants and types for the port extended configuration register bank
// Assumes: 32-bit plain register port, byte offsets, core clock 20 MHz
package pecr_pkg;
    localparam logic [11:0] PECR_OFS_CAP = 12'h264;
    localparam logic [11:0] PECR_OFS_CTL = 12'h268;
    localparam logic [11:0] PECR_OFS_WAIT = 12'h300;
    localparam logic [11:0] PECR_OFS_DLY = 12'h304;
    localparam logic [11:0] PECR_OFS_SPA = 12'h308;
    localparam logic [11:0] PECR_OFS_SPB = 12'h30C;
    localparam logic [11:0] PECR_OFS_SPC = 12'h310;
    localparam logic [11:0] PECR_OFS_TALLY = 12'h318;
    localparam logic [11:0] PECR_OFS_IRQ_STS = 12'h3F0;
    localparam logic [11:0] PECR_OFS_IRQ_MSK = 12'h3F4;

    localparam logic [19:0] PECR_WAIT_RST = 20'h00FFF;
    localparam logic [15:0] PECR_DLY_RST = 16'h01FF;
    localparam logic [31:0] PECR_SPC_RST = 32'h000FFFFF;
    localparam logic [7:0] PECR_CLK_GRAN_RST = 8'h00;
    localparam logic [2:0] PECR_CAP_ROLES = 3'h7;

    // Timing: units as printed, cycle figures derived from the 50 ns clock
    localparam int PECR_CLK_NS = 50;
    localparam int PECR_WAIT_UNIT_NS = 10;
    localparam int PECR_DLY_UNIT_NS = 4;

    // Field positions
    localparam int PECR_CTL_EN_BIT = 0;
    localparam int PECR_CTL_ROOT_BIT = 1;
    localparam int PECR_TALLY_CLR_BIT = 30;
    localparam int PECR_TALLY_EN_BIT = 31;

    // Interrupt status bits
    localparam int PECR_IRQ_CPL = 0;
    localparam int PECR_IRQ_NP = 1;
    localparam int PECR_IRQ_POST = 2;
    localparam int PECR_IRQ_TIMEOUT = 3;
    localparam int PECR_IRQ_W = 4;

    typedef enum logic [4:0] {
        PECR_SRC_TRAIN = 5'h00,
        PECR_SRC_UNCORR = 5'h01,
        PECR_SRC_ACS = 5'h03,
        PECR_SRC_RPL_ROLL = 5'h04,
        PECR_SRC_RPL_TMO = 5'h05,
        PECR_SRC_CPL_CRED = 5'h07,
        PECR_SRC_NP_CRED = 5'h08,
        PECR_SRC_POST_CRED = 5'h09,
        PECR_SRC_RX_NACK_A = 5'h0A,
        PECR_SRC_RX_NACK_B = 5'h0B,
        PECR_SRC_RX_RECOV = 5'h0C,
        PECR_SRC_TX_RECOV = 5'h0D
    } pecr_src_t;

    typedef struct packed {
        logic training;
        logic uncorrectable_status;
        logic acs;
        logic replay_rollover;
        logic replay_timeout;
        logic cpl_credit;
        logic np_credit;
        logic post_credit;
        logic rx_nack;
        logic rx_recovery;
        logic tx_recovery;
    } pecr_err_t;

    typedef enum logic [1:0] {
        PECR_ST_L1 = 2'b00,
        PECR_ST_WAIT = 2'b01,
        PECR_ST_L11 = 2'b11
    } pecr_state_t;
endpackage : pecr_pkg

// ### hdl/pecr_regs.sv
// Purpose: Port extended configuration registers with L1.1 clock request handshake and error tally
// Assumes: Single 20 MHz clock, synchronous active-high reset, clock request pin open drain
// Notes: Delay counters round to whole cycles; link state machine drives the L1/entry requests
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module pecr_regs
    import pecr_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Register port
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Link state machine view
    input wire logic link_in_l1,
    input wire logic aspm_mode,
    output logic substate_active,
    output logic ptm_enabled,
    output logic ptm_root,
    // Shared clock request line, active low
    input wire logic clkreq_n_in,
    output logic clkreq_n_out,
    output logic clkreq_n_oe,
    // Error events, one-cycle pulses
    input wire pecr_err_t err_events,
    // Interrupt
    output logic irq
);
    logic [7:0] gran_q;
    logic ctl_en_q;
    logic ctl_root_q;
    logic [7:0] eff_gran_q;
    logic [19:0] wait_q;
    logic [15:0] pm_dly_q;
    logic [15:0] aspm_dly_q;
    logic [31:0] spa_q;
    logic [31:0] spb_q;
    logic [31:0] spc_q;
    logic [15:0] tally_q;
    logic [2:0] cred_q;
    logic [4:0] src_q;
    logic tally_en_q;
    logic [PECR_IRQ_W-1:0] irq_sts_q;
    logic [PECR_IRQ_W-1:0] irq_msk_q;
    logic [31:0] rdata_q;
    logic clkreq_s1_q;
    logic clkreq_s2_q;
    pecr_state_t state_q;
    logic [27:0] timer_q;
    logic timeout_evt;
    logic hit;

    function automatic logic wr_at(input logic [11:0] ofs);
        wr_at = reg_wr && (reg_addr == ofs);
    endfunction : wr_at

    // Capability granularity is read-only; held for a future strap load
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            gran_q <= PECR_CLK_GRAN_RST;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctl_en_q <= 1'b0;
            ctl_root_q <= 1'b0;
            eff_gran_q <= 8'h00;
        end else if (wr_at(PECR_OFS_CTL)) begin
            ctl_en_q <= reg_wdata[PECR_CTL_EN_BIT];
            ctl_root_q <= reg_wdata[PECR_CTL_ROOT_BIT];
            eff_gran_q <= reg_wdata[15:8];
        end
    end

    assign ptm_enabled = ctl_en_q;
    assign ptm_root = ctl_en_q && ctl_root_q;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wait_q <= PECR_WAIT_RST;
            pm_dly_q <= PECR_DLY_RST;
            aspm_dly_q <= PECR_DLY_RST;
            spa_q <= 32'h00000000;
            spb_q <= 32'h00000000;
            spc_q <= PECR_SPC_RST;
        end else begin
            if (wr_at(PECR_OFS_WAIT)) begin
                wait_q <= reg_wdata[19:0];
            end
            if (wr_at(PECR_OFS_DLY)) begin
                pm_dly_q <= reg_wdata[15:0];
                aspm_dly_q <= reg_wdata[31:16];
            end
            if (wr_at(PECR_OFS_SPA)) begin
                spa_q <= reg_wdata;
            end
            if (wr_at(PECR_OFS_SPB)) begin
                spb_q <= reg_wdata;
            end
            if (wr_at(PECR_OFS_SPC)) begin
                spc_q <= reg_wdata;
            end
        end
    end

    // Pin synchroniser; only the second stage is read
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            clkreq_s1_q <= 1'b1;
            clkreq_s2_q <= 1'b1;
        end else begin
            clkreq_s1_q <= clkreq_n_in;
            clkreq_s2_q <= clkreq_s1_q;
        end
    end

    // Delay counts in cycles: longest-time rounding down, at least one cycle
    function automatic logic [27:0] to_cycles(input logic [19:0] cnt, input int unit_ns);
        logic [27:0] c;
        c = 28'((32'(cnt) * 32'(unit_ns)) / 32'(PECR_CLK_NS));
        to_cycles = (c == 28'h0) ? 28'h1 : c;
    endfunction : to_cycles

    logic [27:0] entry_cycles;
    logic [27:0] wait_cycles;
    assign entry_cycles = aspm_mode ? to_cycles({4'h0, aspm_dly_q}, PECR_DLY_UNIT_NS)
                                    : to_cycles({4'h0, pm_dly_q}, PECR_DLY_UNIT_NS);
    assign wait_cycles = to_cycles(wait_q, PECR_WAIT_UNIT_NS);

    // L1 dwell, release handshake, then L1.1; a stuck line sends us back to L1
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q <= PECR_ST_L1;
            timer_q <= 28'h0;
        end else if (!link_in_l1) begin
            state_q <= PECR_ST_L1;
            timer_q <= 28'h0;
        end else begin
            case (state_q)
                PECR_ST_L1: begin
                    if (timer_q + 28'h1 >= entry_cycles) begin
                        state_q <= PECR_ST_WAIT;
                        timer_q <= 28'h0;
                    end else begin
                        timer_q <= timer_q + 28'h1;
                    end
                end
                PECR_ST_WAIT: begin
                    if (clkreq_s2_q) begin
                        state_q <= PECR_ST_L11;
                        timer_q <= 28'h0;
                    end else if (timer_q + 28'h1 >= wait_cycles) begin
                        state_q <= PECR_ST_L1;
                        timer_q <= 28'h0;
                    end else begin
                        timer_q <= timer_q + 28'h1;
                    end
                end
                PECR_ST_L11: begin
                    timer_q <= 28'h0;
                end
                default: begin
                    state_q <= PECR_ST_L1;
                    timer_q <= 28'h0;
                end
            endcase
        end
    end

    assign timeout_evt = link_in_l1 && (state_q == PECR_ST_WAIT) && !clkreq_s2_q
                         && (timer_q + 28'h1 >= wait_cycles);
    assign substate_active = (state_q == PECR_ST_L11);
    // Drive low (asserted) except once L1.1 entry has started
    assign clkreq_n_out = 1'b0;
    assign clkreq_n_oe = (state_q == PECR_ST_L1);

    // Error source decode
    logic src_hit;
    always_comb begin
        src_hit = 1'b0;
        case (src_q)
            PECR_SRC_TRAIN: src_hit = err_events.training;
            PECR_SRC_UNCORR: src_hit = err_events.uncorrectable_status;
            PECR_SRC_ACS: src_hit = err_events.acs;
            PECR_SRC_RPL_ROLL: src_hit = err_events.replay_rollover;
            PECR_SRC_RPL_TMO: src_hit = err_events.replay_timeout;
            PECR_SRC_CPL_CRED: src_hit = err_events.cpl_credit;
            PECR_SRC_NP_CRED: src_hit = err_events.np_credit;
            PECR_SRC_POST_CRED: src_hit = err_events.post_credit;
            PECR_SRC_RX_NACK_A: src_hit = err_events.rx_nack;
            PECR_SRC_RX_NACK_B: src_hit = err_events.rx_nack;
            PECR_SRC_RX_RECOV: src_hit = err_events.rx_recovery;
            PECR_SRC_TX_RECOV: src_hit = err_events.tx_recovery;
            default: src_hit = 1'b0;
        endcase
    end

    logic tally_wr;
    assign tally_wr = wr_at(PECR_OFS_TALLY);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            src_q <= 5'h00;
            tally_en_q <= 1'b0;
        end else if (tally_wr) begin
            src_q <= reg_wdata[28:24];
            tally_en_q <= reg_wdata[PECR_TALLY_EN_BIT];
        end
    end

    // Clear wins over a coincident count; it is a command, not an event flag
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tally_q <= 16'h0000;
        end else if (tally_wr && reg_wdata[PECR_TALLY_CLR_BIT]) begin
            tally_q <= 16'h0000;
        end else if (tally_en_q && src_hit && tally_q != 16'hFFFF) begin
            tally_q <= tally_q + 16'h0001;
        end
    end

    // Sticky credit flags: set beats write-one clear
    logic [2:0] cred_set;
    assign cred_set = {err_events.post_credit, err_events.np_credit, err_events.cpl_credit};
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cred_q <= 3'h0;
        end else begin
            cred_q <= (cred_q & ~(tally_wr ? reg_wdata[18:16] : 3'h0)) | cred_set;
        end
    end

    logic [PECR_IRQ_W-1:0] irq_set;
    assign irq_set = {timeout_evt, cred_set};
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_sts_q <= '0;
            irq_msk_q <= '0;
        end else begin
            irq_sts_q <= (irq_sts_q & ~(wr_at(PECR_OFS_IRQ_STS) ? reg_wdata[PECR_IRQ_W-1:0] : '0)) | irq_set;
            if (wr_at(PECR_OFS_IRQ_MSK)) begin
                irq_msk_q <= reg_wdata[PECR_IRQ_W-1:0];
            end
        end
    end
    // A set mask bit hides its status bit from the interrupt line
    assign irq = |(irq_sts_q & ~irq_msk_q);

    // Read mux; unmapped offsets read zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        hit = 1'b1;
        case (reg_addr)
            PECR_OFS_CAP: rd_mux = {16'h0000, gran_q, 5'h00, PECR_CAP_ROLES};
            PECR_OFS_CTL: rd_mux = {16'h0000, eff_gran_q, 6'h00, ctl_root_q, ctl_en_q};
            PECR_OFS_WAIT: rd_mux = {12'h000, wait_q};
            PECR_OFS_DLY: rd_mux = {aspm_dly_q, pm_dly_q};
            PECR_OFS_SPA: rd_mux = spa_q;
            PECR_OFS_SPB: rd_mux = spb_q;
            PECR_OFS_SPC: rd_mux = spc_q;
            PECR_OFS_TALLY: rd_mux = {tally_en_q, 1'b1, 1'b0, src_q, 5'h00, cred_q, tally_q};
            PECR_OFS_IRQ_STS: rd_mux = {{(32-PECR_IRQ_W){1'b0}}, irq_sts_q};
            PECR_OFS_IRQ_MSK: rd_mux = {{(32-PECR_IRQ_W){1'b0}}, irq_msk_q};
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= (reg_rd && hit) ? rd_mux : 32'h00000000;
        end
    end
    assign reg_rdata = rdata_q;

    // Assertions
    sequence s_release;
        state_q == PECR_ST_WAIT && !clkreq_s2_q && link_in_l1;
    endsequence
    sequence s_dwell_done;
        state_q == PECR_ST_L1 && link_in_l1 && (timer_q + 28'h1 >= entry_cycles);
    endsequence

    a_root_needs_en: assert property (@(posedge sys_clk) disable iff (reset)
        ptm_root |-> ptm_enabled)
        else $error("root role without enable");
    a_cap_read_ones: assert property (@(posedge sys_clk) disable iff (reset)
        (reg_rd && reg_addr == PECR_OFS_CAP) |=> reg_rdata[2:0] == PECR_CAP_ROLES)
        else $error("capability roles not read as ones");
    a_clear_reads_one: assert property (@(posedge sys_clk) disable iff (reset)
        (reg_rd && reg_addr == PECR_OFS_TALLY) |=> reg_rdata[PECR_TALLY_CLR_BIT])
        else $error("clear bit did not read one");
    a_release_drive: assert property (@(posedge sys_clk) disable iff (reset)
        s_dwell_done |=> !clkreq_n_oe)
        else $error("clock request still driven in substate entry");
    a_stuck_reassert: assert property (@(posedge sys_clk) disable iff (reset)
        (s_release and timeout_evt) |=> clkreq_n_oe && state_q == PECR_ST_L1)
        else $error("stuck clock request not reasserted");
    a_count_gated: assert property (@(posedge sys_clk) disable iff (reset)
        (!tally_en_q && !tally_wr) |=> $stable(tally_q))
        else $error("counter moved while disabled");
    a_clear_zeroes: assert property (@(posedge sys_clk) disable iff (reset)
        (tally_wr && reg_wdata[PECR_TALLY_CLR_BIT]) |=> tally_q == 16'h0000)
        else $error("counter not cleared");
    a_flag_sticky: assert property (@(posedge sys_clk) disable iff (reset)
        err_events.cpl_credit |=> cred_q[0])
        else $error("credit flag lost");
    a_gran_passive: assert property (@(posedge sys_clk) disable iff (reset)
        (reg_wr && reg_addr == PECR_OFS_CTL && reg_wdata[PECR_CTL_EN_BIT] == ctl_en_q
            && reg_wdata[PECR_CTL_ROOT_BIT] == ctl_root_q) |=> $stable(ptm_enabled) && $stable(ptm_root))
        else $error("granularity changed behaviour");
endmodule : pecr_regs
`default_nettype wire

// ### testbench/pecr_partner.sv
// Purpose: Link partner end of the shared open-drain clock request line
// Assumes: Partner pulls the line low whenever the link is out of L1
// Notes: Release delay and a stuck mode are set by the bench
`timescale 1ns/1ns
`default_nettype none
module pecr_partner (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Link view and bench controls
    input wire logic in_l1,
    input wire logic stuck,
    input wire logic [7:0] rel_delay,
    // Open-drain pull, high while pulling the line low
    output logic pull_low
);
    logic [7:0] cnt_q;

    // A stuck partner keeps the clock requested, which forces the port back to L1
    always_ff @(posedge sys_clk) begin
        if (reset || !in_l1) begin
            cnt_q <= 8'h00;
            pull_low <= 1'b1;
        end else if (cnt_q != rel_delay) begin
            cnt_q <= cnt_q + 8'h01;
        end else if (!stuck) begin
            pull_low <= 1'b0;
        end
    end
endmodule : pecr_partner
`default_nettype wire

// ### testbench/tb.sv
// Purpose: Self-checking bench for the port extended configuration registers
// Assumes: 20 MHz clock, registers reached over the plain strobe port
// Notes: Expected words come from an integer model; link timings are checked as windows
`timescale 1ns/1ns
`default_nettype none
module tb;
    import pecr_pkg::*;
    logic sys_clk, reset, reg_wr, reg_rd, link_in_l1, aspm_mode, stuck, pull_low;
    logic substate_active, ptm_enabled, ptm_root, clkreq_n_out, clkreq_n_oe, irq;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [7:0] rel_delay;
    pecr_err_t err_events;
    wire logic line_n;
    int n_errors, samples_checked, c, sb;
    int unsigned sts, d, cnt, flg;
    int k[11];
    logic [11:0] ofs[8] = '{PECR_OFS_CAP, PECR_OFS_CTL, PECR_OFS_WAIT, PECR_OFS_DLY, PECR_OFS_SPA,
        PECR_OFS_SPB, PECR_OFS_SPC, 12'h200};
    int unsigned rstv[8] = '{32'h7, 0, 32'hFFF, 32'h01FF01FF, 0, 0, 32'hFFFFF, 0};
    int unsigned msk[8] = '{0, 32'hFF03, 32'hFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 0};

    // Pull-up on the line: low while either party pulls
    assign line_n = !((clkreq_n_oe && !clkreq_n_out) || pull_low);

    pecr_regs uut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_in_l1(link_in_l1),
        .aspm_mode(aspm_mode), .substate_active(substate_active), .ptm_enabled(ptm_enabled),
        .ptm_root(ptm_root), .clkreq_n_in(line_n), .clkreq_n_out(clkreq_n_out),
        .clkreq_n_oe(clkreq_n_oe), .err_events(err_events), .irq(irq));

    pecr_partner partner (.sys_clk(sys_clk), .reset(reset), .in_l1(link_in_l1), .stuck(stuck),
        .rel_delay(rel_delay), .pull_low(pull_low));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = !sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up;
        $display("compares %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask : rd_chk

    task automatic pulse(input int b);
        @(posedge sys_clk);
        err_events <= pecr_err_t'(11'h001 << b);
        @(posedge sys_clk);
        err_events <= '0;
    endtask : pulse

    // Cycles until the port's drive enable reaches the given level, bounded
    task automatic wait_oe(input logic lvl, output int n);
        n = 0;
        while (clkreq_n_oe !== lvl) begin
            tick();
            n++;
            if (n > 500) begin
                n_errors++;
                $display("BAD t=%0t drive enable never changed", $time);
                wrap_up();
            end
        end
    endtask : wait_oe

    task automatic link_run(input logic asp, input logic stk, input logic [7:0] rel, input int ent, input int wt);
        @(posedge sys_clk);
        aspm_mode <= asp;
        stuck <= stk;
        rel_delay <= rel;
        link_in_l1 <= 1'b1;
        wait_oe(1'b0, c);
        check(32'(c >= ent - 1 && c <= ent + 3), 32'h1);
        if (stk) begin
            wait_oe(1'b1, c);
            check(32'(c >= wt && c <= wt + 4), 32'h1);
            check(32'(substate_active), 32'h0);
            sts = sts | 32'h8;
            check(32'(irq), 32'h1);
        end else begin
            for (int i = 0; i < 60 && substate_active !== 1'b1; i++) tick();
            check(32'(substate_active), 32'h1);
            check(32'(clkreq_n_oe), 32'h0);
        end
        @(posedge sys_clk);
        link_in_l1 <= 1'b0;
        wait_oe(1'b1, c);
        rd_chk(PECR_OFS_IRQ_STS, sts);
        wr(PECR_OFS_IRQ_STS, sts);
        sts = 0;
    endtask : link_run

    // Counted bit of the error event struct for a source code, -1 when reserved
    function automatic int src_bit(input int code);
        case (code)
            0: return 10;
            1: return 9;
            3: return 8;
            4: return 7;
            5: return 6;
            7: return 5;
            8: return 4;
            9: return 3;
            10, 11: return 2;
            12: return 1;
            13: return 0;
            default: return -1;
        endcase
    endfunction : src_bit

    initial begin
        reset = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 12'h000;
        reg_wdata = 32'h0;
        link_in_l1 = 1'b0;
        aspm_mode = 1'b0;
        stuck = 1'b0;
        rel_delay = 8'h00;
        err_events = '0;
        sts = 0;
        void'($urandom(33));
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        tick();
        check(32'(clkreq_n_oe), 32'h1);
        check(32'(irq), 32'h0);
        for (int i = 0; i < 8; i++) rd_chk(ofs[i], rstv[i]);
        rd_chk(PECR_OFS_TALLY, 32'h40000000);
        for (int i = 0; i < 8; i++) begin
            d = $urandom;
            wr(ofs[i], d);
            rd_chk(ofs[i], (d & msk[i]) | rstv[0] * (i == 0));
        end
        for (int v = 0; v < 4; v++) begin
            wr(PECR_OFS_CTL, ($urandom & 32'hFF00) | v);
            #1;
            check(32'(ptm_enabled), 32'(v & 1));
            check(32'(ptm_root), 32'(v == 3));
        end
        // Same role bits, new granularity: roles must not move
        wr(PECR_OFS_CTL, ($urandom & 32'hFF00) | 32'h3);
        #1;
        check(32'(ptm_root), 32'h1);
        wr(PECR_OFS_IRQ_MSK, 32'h0);
        for (int code = 0; code < 32; code++) begin
            wr(PECR_OFS_TALLY, 32'hC0070000 | (code << 24));
            foreach (k[b]) k[b] = $urandom_range(0, 3);
            foreach (k[b]) repeat (k[b]) pulse(b);
            sb = src_bit(code);
            cnt = (sb < 0) ? 0 : k[sb];
            flg = (k[5] > 0) | ((k[4] > 0) << 1) | ((k[3] > 0) << 2);
            sts = sts | flg;
            rd_chk(PECR_OFS_TALLY, 32'hC0000000 | (code << 24) | (flg << 16) | cnt);
        end
        rd_chk(PECR_OFS_IRQ_STS, sts);
        wr(PECR_OFS_IRQ_MSK, 32'hF);
        tick();
        check(32'(irq), 32'h0);
        wr(PECR_OFS_IRQ_MSK, 32'h0);
        tick();
        check(32'(irq), 32'(sts != 0));
        wr(PECR_OFS_IRQ_STS, sts);
        sts = 0;
        rd_chk(PECR_OFS_IRQ_STS, 32'h0);
        wr(PECR_OFS_TALLY, 32'h40070000);
        repeat (2) pulse(10);
        rd_chk(PECR_OFS_TALLY, 32'h40000000);
        wr(PECR_OFS_TALLY, 32'h80000000);
        repeat (3) pulse(10);
        rd_chk(PECR_OFS_TALLY, 32'hC0000003);
        wr(PECR_OFS_TALLY, 32'hC0000000);
        rd_chk(PECR_OFS_TALLY, 32'hC0000000);
        // Entry: PM 250 counts gives 20 cycles, ASPM 3 counts rounds up to 1
        wr(PECR_OFS_DLY, 32'h000300FA);
        wr(PECR_OFS_WAIT, 32'd20);
        link_run(1'b0, 1'b0, 8'd0, 20, 4);
        link_run(1'b1, 1'b1, 8'd0, 1, 4);
        wr(PECR_OFS_WAIT, 32'd100);
        link_run(1'b1, 1'b0, 8'd12, 1, 20);
        link_run(1'b1, 1'b1, 8'd0, 1, 20);
        wrap_up();
    end
endmodule : tb
`default_nettype wire
